/* File: core/scsf_pkg.sv */
package scsf_pkg;
    // Command opcodes
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_SENSE = 8'h03;
    localparam logic [3:0] CMD_SEEK_HI = 4'h7;
    localparam logic [7:0] CMD_SETF = 8'hEF;
    // Set Features sub-codes
    localparam logic [7:0] SF_8BIT_ON = 8'h01;
    localparam logic [7:0] SF_WC_ON = 8'h02;
    localparam logic [7:0] SF_XFER = 8'h03;
    localparam logic [7:0] SF_APM_ON = 8'h05;
    localparam logic [7:0] SF_PL1_ON = 8'h0A;
    localparam logic [7:0] SF_ECC_VS = 8'h44;
    localparam logic [7:0] SF_RLA_OFF = 8'h55;
    localparam logic [7:0] SF_POR_OFF = 8'h66;
    localparam logic [7:0] SF_NOP69 = 8'h69;
    localparam logic [7:0] SF_8BIT_OFF = 8'h81;
    localparam logic [7:0] SF_WC_OFF = 8'h82;
    localparam logic [7:0] SF_APM_OFF = 8'h85;
    localparam logic [7:0] SF_PL1_OFF = 8'h8A;
    localparam logic [7:0] SF_NOP96 = 8'h96;
    localparam logic [7:0] SF_NOP97 = 8'h97;
    localparam logic [7:0] SF_RLA_ON = 8'hAA;
    localparam logic [7:0] SF_ECC_4 = 8'hBB;
    localparam logic [7:0] SF_POR_ON = 8'hCC;
    // Transfer type field (sector count bits 7:3)
    localparam logic [4:0] XT_PIO_DEF = 5'h00;
    localparam logic [4:0] XT_PIO = 5'h01;
    localparam logic [4:0] XT_MDMA = 5'h04;
    localparam logic [2:0] PIO_MAX = 3'h6;
    localparam logic [2:0] MDMA_MAX = 3'h4;
    // Extended error codes
    localparam logic [7:0] EE_NONE = 8'h00;
    localparam logic [7:0] EE_SELFTEST_OK = 8'h01;
    localparam logic [7:0] EE_INVALID_CMD = 8'h20;
    localparam logic [7:0] EE_INVALID_ADDR = 8'h21;
    localparam logic [7:0] EE_PL1_DISABLED = 8'h22;
    localparam logic [7:0] EE_ADDR_OVF = 8'h2F;
    localparam logic [7:0] EE_VOLT_SUPPLY = 8'h35;
    localparam logic [7:0] EE_VOLT_GEN = 8'h36;
    localparam logic [7:0] EE_DIAG_BASE = 8'h30;
    localparam logic [7:0] EE_XFER_ABORT = 8'h1F;
    // Error register abort bit
    localparam logic [7:0] ERR_ABRT = 8'h04;
    // Wishbone register offsets (bytes)
    localparam logic [5:0] A_ERROR = 6'h04;
    localparam logic [5:0] A_SECCNT = 6'h08;
    localparam logic [5:0] A_SECNUM = 6'h0C;
    localparam logic [5:0] A_CYLLO = 6'h10;
    localparam logic [5:0] A_CYLHI = 6'h14;
    localparam logic [5:0] A_DRVHD = 6'h18;
    localparam logic [5:0] A_CMDSTAT = 6'h1C;
    localparam logic [5:0] A_MODES = 6'h20;
    localparam logic [5:0] A_TARGET = 6'h24;
    localparam logic [5:0] A_CAP = 6'h28;
    localparam logic [5:0] A_FEATURE = 6'h00;
    // Status bits
    localparam int ST_BSY = 7;
    localparam int ST_DRDY = 6;
    localparam int ST_ERR = 0;
    // Media capacity in sectors (plain default)
    localparam logic [27:0] CAP_DEF = 28'h0FFFFFF;
    localparam logic [3:0] HEADS_DEF = 4'hF;
    localparam logic [7:0] SPT_DEF = 8'h3F;
    // Last execute-counter value; the execute state lasts one cycle more
    localparam logic [3:0] EXEC_CYC = 4'h2;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_EXEC = 4'b0010,
        ST_FLUSH = 4'b0100,
        ST_DONE = 4'b1000
    } state_type;
endpackage

/* File: core/scsf_core.sv */
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/1ps
module scsf_core (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Device events (from media and supply logic, other domains)
    input wire logic soft_reset_i,
    input wire logic selftest_done_i,
    input wire logic selftest_fail_i,
    input wire logic [2:0] selftest_code_i,
    input wire logic volt_supply_bad_i,
    input wire logic volt_gen_bad_i,
    input wire logic xfer_error_i,
    input wire logic pl1_cmd_i,
    input wire logic flush_done_i,
    input wire logic data_reg_access_i,
    // Mode outputs
    output logic eight_bit_o,
    output logic wide_io_indicator_n_o,
    output logic write_cache_o,
    output logic flush_req_o,
    output logic read_ahead_o,
    output logic apm_o,
    output logic pl1_enable_o,
    output logic ecc_four_o,
    output logic [2:0] pio_mode_o,
    output logic [2:0] mdma_mode_o,
    output logic seek_o,
    output logic [27:0] seek_target_o,
    output logic busy_o
);
    localparam int NSYNC = 9;
    // Status words; the error bit is or-ed in at completion
    localparam logic [7:0] STAT_READY = 8'h40;
    localparam logic [7:0] STAT_BUSY = 8'h80;
    localparam logic [2:0] DIAG_TOP = 3'h4;

    // Event inputs come from other clock domains
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [NSYNC-1:0] sync3;
    assign raw_in = {soft_reset_i, selftest_done_i, selftest_fail_i, volt_supply_bad_i,
        volt_gen_bad_i, xfer_error_i, pl1_cmd_i, flush_done_i, data_reg_access_i};
    // Third stage feeds only the edge detectors
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                    sync3[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= raw_in[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                end
            end
        end
    endgenerate

    logic [2:0] st_code_s1;
    logic [2:0] st_code_s2;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_code_s1 <= 3'h0;
            st_code_s2 <= 3'h0;
        end else begin
            st_code_s1 <= selftest_code_i;
            st_code_s2 <= st_code_s1;
        end
    end

    wire soft_rst_rise = sync2[8] & ~sync3[8];
    wire st_done_rise = sync2[7] & ~sync3[7];
    wire st_fail = sync2[6];
    wire vsup_rise = sync2[5] & ~sync3[5];
    wire vgen_rise = sync2[4] & ~sync3[4];
    wire xerr_rise = sync2[3] & ~sync3[3];
    wire pl1_rise = sync2[2] & ~sync3[2];
    wire flush_done = sync2[1];
    wire data_acc = sync2[0];
    // Failure codes above the top one fold onto it
    wire [2:0] diag_sel = (st_code_s2 > DIAG_TOP) ? DIAG_TOP : st_code_s2;
    wire [7:0] diag_code = scsf_pkg::EE_DIAG_BASE | {5'h00, diag_sel};
    wire [7:0] st_code_ee = st_fail ? diag_code : scsf_pkg::EE_SELFTEST_OK;

    // Task file registers
    logic [7:0] feature;
    logic [7:0] seccnt;
    logic [7:0] secnum;
    logic [7:0] cyllo;
    logic [7:0] cylhi;
    logic [7:0] drvhd;
    logic [7:0] command;
    logic [7:0] error;
    logic [7:0] status;
    logic [7:0] ext_code;
    logic [27:0] capacity;
    scsf_pkg::state_type state;
    scsf_pkg::state_type next_state;
    logic [3:0] exec_cnt;
    logic por_keep;

    // Bus decode
    // Writes while busy are acked but dropped, so the host never stalls
    wire bus_req = cyc_i & stb_i & ~ack_o;
    wire bus_wr = bus_req & we_i & sel_i[0];
    wire hit_cmd = adr_i == scsf_pkg::A_CMDSTAT;
    wire cmd_wr = bus_wr & hit_cmd & ~status[scsf_pkg::ST_BSY];
    wire tf_wr = bus_wr & ~status[scsf_pkg::ST_BSY];
    logic [31:0] rd_mux;
    always_comb begin
        unique case (adr_i)
            scsf_pkg::A_FEATURE: rd_mux = {24'h000000, feature};
            scsf_pkg::A_ERROR: rd_mux = {24'h000000, error};
            scsf_pkg::A_SECCNT: rd_mux = {24'h000000, seccnt};
            scsf_pkg::A_SECNUM: rd_mux = {24'h000000, secnum};
            scsf_pkg::A_CYLLO: rd_mux = {24'h000000, cyllo};
            scsf_pkg::A_CYLHI: rd_mux = {24'h000000, cylhi};
            scsf_pkg::A_DRVHD: rd_mux = {24'h000000, drvhd};
            scsf_pkg::A_CMDSTAT: rd_mux = {24'h000000, status};
            scsf_pkg::A_MODES: rd_mux = {16'h0000, 2'h0, mdma_mode_o, pio_mode_o,
                ecc_four_o, pl1_enable_o, apm_o, read_ahead_o, write_cache_o, eight_bit_o,
                por_keep, 1'b0};
            scsf_pkg::A_TARGET: rd_mux = {4'h0, seek_target_o};
            scsf_pkg::A_CAP: rd_mux = {4'h0, capacity};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Command decode
    wire is_seek = command[7:4] == scsf_pkg::CMD_SEEK_HI;
    wire lba_mode = drvhd[6];
    wire [27:0] lba_addr = {drvhd[3:0], cylhi, cyllo, secnum};
    // CHS: sector number must be 1..SPT, head below head count
    wire chs_bad = (secnum == 8'h00) | (secnum > scsf_pkg::SPT_DEF)
        | (drvhd[3:0] > scsf_pkg::HEADS_DEF);
    // Full-width terms: a 4-bit head count plus one would wrap to zero
    wire [27:0] heads_cnt = 28'(scsf_pkg::HEADS_DEF) + 28'h0000001;
    wire [27:0] spt_cnt = 28'(scsf_pkg::SPT_DEF);
    wire [27:0] cyl_num = 28'({cylhi, cyllo});
    wire [27:0] head_num = 28'(drvhd[3:0]);
    wire [27:0] sec_idx = 28'(secnum) - 28'h0000001;
    wire [27:0] chs_lin = (cyl_num * heads_cnt + head_num) * spt_cnt + sec_idx;
    wire [27:0] target = lba_mode ? lba_addr : chs_lin;
    wire [4:0] xt = seccnt[7:3];
    wire [2:0] xm = seccnt[2:0];
    wire xfer_ok = ((xt == scsf_pkg::XT_PIO_DEF) & (xm == 3'h0))
        | ((xt == scsf_pkg::XT_PIO) & (xm <= scsf_pkg::PIO_MAX))
        | ((xt == scsf_pkg::XT_MDMA) & (xm <= scsf_pkg::MDMA_MAX));

    wire sf_known = (feature == scsf_pkg::SF_8BIT_ON) | (feature == scsf_pkg::SF_WC_ON)
        | (feature == scsf_pkg::SF_APM_ON) | (feature == scsf_pkg::SF_PL1_ON)
        | (feature == scsf_pkg::SF_ECC_VS) | (feature == scsf_pkg::SF_RLA_OFF)
        | (feature == scsf_pkg::SF_POR_OFF) | (feature == scsf_pkg::SF_NOP69)
        | (feature == scsf_pkg::SF_8BIT_OFF) | (feature == scsf_pkg::SF_WC_OFF)
        | (feature == scsf_pkg::SF_APM_OFF) | (feature == scsf_pkg::SF_PL1_OFF)
        | (feature == scsf_pkg::SF_NOP96) | (feature == scsf_pkg::SF_NOP97)
        | (feature == scsf_pkg::SF_RLA_ON) | (feature == scsf_pkg::SF_ECC_4)
        | (feature == scsf_pkg::SF_POR_ON) | ((feature == scsf_pkg::SF_XFER) & xfer_ok);

    // Fixed execution time; the counter clears outside execute
    wire exec_end = (state == scsf_pkg::ST_EXEC) & (exec_cnt == scsf_pkg::EXEC_CYC);
    wire is_sf = command == scsf_pkg::CMD_SETF;
    wire wc_flush = exec_end & is_sf & (feature == scsf_pkg::SF_WC_OFF);
    wire seek_bad = ~lba_mode & chs_bad;
    wire seek_ovf = target >= capacity;
    wire seek_ok = exec_end & is_seek & ~seek_bad & ~seek_ovf;
    wire cmd_fail = (command == scsf_pkg::CMD_NOP)
        | (is_seek & (seek_bad | seek_ovf)) | (is_sf & ~sf_known)
        | ~(is_seek | is_sf | (command == scsf_pkg::CMD_SENSE));

    logic [7:0] fail_code;
    always_comb begin
        if (is_seek & seek_bad) begin
            fail_code = scsf_pkg::EE_INVALID_ADDR;
        end else if (is_seek) begin
            fail_code = scsf_pkg::EE_ADDR_OVF;
        end else if (command == scsf_pkg::CMD_NOP) begin
            fail_code = scsf_pkg::EE_XFER_ABORT;
        end else begin
            fail_code = scsf_pkg::EE_INVALID_CMD;
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            scsf_pkg::ST_IDLE: if (cmd_wr) next_state = scsf_pkg::ST_EXEC;
            scsf_pkg::ST_EXEC: if (exec_end) begin
                next_state = wc_flush ? scsf_pkg::ST_FLUSH : scsf_pkg::ST_DONE;
            end
            scsf_pkg::ST_FLUSH: if (flush_done) next_state = scsf_pkg::ST_DONE;
            scsf_pkg::ST_DONE: next_state = scsf_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= scsf_pkg::ST_IDLE;
            exec_cnt <= 4'h0;
        end else begin
            state <= next_state;
            exec_cnt <= (state == scsf_pkg::ST_EXEC) ? exec_cnt + 4'h1 : 4'h0;
        end
    end

    // Bus answer and task file writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
            feature <= 8'h00;
            seccnt <= 8'h00;
            secnum <= 8'h00;
            cyllo <= 8'h00;
            cylhi <= 8'h00;
            drvhd <= 8'h00;
            command <= 8'h00;
            capacity <= scsf_pkg::CAP_DEF;
        end else begin
            ack_o <= bus_req;
            dat_o <= rd_mux;
            if (tf_wr) begin
                unique case (adr_i)
                    scsf_pkg::A_FEATURE: feature <= dat_i[7:0];
                    scsf_pkg::A_SECCNT: seccnt <= dat_i[7:0];
                    scsf_pkg::A_SECNUM: secnum <= dat_i[7:0];
                    scsf_pkg::A_CYLLO: cyllo <= dat_i[7:0];
                    scsf_pkg::A_CYLHI: cylhi <= dat_i[7:0];
                    scsf_pkg::A_DRVHD: drvhd <= dat_i[7:0];
                    scsf_pkg::A_CMDSTAT: command <= dat_i[7:0];
                    scsf_pkg::A_CAP: capacity <= {dat_i[27:24] & {4{sel_i[3]}}, dat_i[23:0]};
                    default: ;
                endcase
            end
        end
    end

    // Extended error code; events win over command completion in same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_code <= scsf_pkg::EE_NONE;
            error <= 8'h00;
            status <= STAT_READY;
        end else begin
            if (cmd_wr) begin
                status <= STAT_BUSY;
            end else if (state == scsf_pkg::ST_DONE) begin
                status <= STAT_READY;
                if (command == scsf_pkg::CMD_SENSE) begin
                    error <= ext_code;
                    ext_code <= scsf_pkg::EE_NONE;
                end else if (cmd_fail) begin
                    error <= scsf_pkg::ERR_ABRT;
                    status[scsf_pkg::ST_ERR] <= 1'b1;
                    ext_code <= fail_code;
                end else begin
                    error <= 8'h00;
                    ext_code <= scsf_pkg::EE_NONE;
                end
            end
            if (st_done_rise) begin
                ext_code <= st_code_ee;
            end else if (vsup_rise) begin
                ext_code <= scsf_pkg::EE_VOLT_SUPPLY;
            end else if (vgen_rise) begin
                ext_code <= scsf_pkg::EE_VOLT_GEN;
            end else if (pl1_rise & ~pl1_enable_o) begin
                ext_code <= scsf_pkg::EE_PL1_DISABLED;
            end else if (xerr_rise) begin
                ext_code <= scsf_pkg::EE_XFER_ABORT;
            end
        end
    end

    // Feature state; soft reset restores defaults unless kept
    wire sf_apply = exec_end & is_sf & sf_known;
    wire restore = soft_rst_rise & ~por_keep;
    always_ff @(posedge clk_i) begin
        if (rst_i | restore) begin
            eight_bit_o <= 1'b0;
            write_cache_o <= 1'b1;
            read_ahead_o <= 1'b1;
            apm_o <= 1'b0;
            pl1_enable_o <= 1'b1;
            ecc_four_o <= 1'b1;
            pio_mode_o <= 3'h0;
            mdma_mode_o <= 3'h0;
            por_keep <= rst_i ? 1'b0 : por_keep;
        end else if (sf_apply) begin
            unique case (feature)
                scsf_pkg::SF_8BIT_ON: eight_bit_o <= 1'b1;
                scsf_pkg::SF_8BIT_OFF: eight_bit_o <= 1'b0;
                scsf_pkg::SF_WC_ON: write_cache_o <= 1'b1;
                scsf_pkg::SF_WC_OFF: write_cache_o <= 1'b0;
                scsf_pkg::SF_APM_ON: apm_o <= 1'b1;
                scsf_pkg::SF_APM_OFF: apm_o <= 1'b0;
                scsf_pkg::SF_PL1_ON: pl1_enable_o <= 1'b1;
                scsf_pkg::SF_PL1_OFF: pl1_enable_o <= 1'b0;
                scsf_pkg::SF_RLA_OFF: read_ahead_o <= 1'b0;
                scsf_pkg::SF_RLA_ON: read_ahead_o <= 1'b1;
                scsf_pkg::SF_POR_OFF: por_keep <= 1'b1;
                scsf_pkg::SF_POR_ON: por_keep <= 1'b0;
                scsf_pkg::SF_ECC_4: ecc_four_o <= 1'b1;
                scsf_pkg::SF_ECC_VS: ecc_four_o <= 1'b0;
                scsf_pkg::SF_XFER: begin
                    // One mode of each kind always held; only the named kind changes
                    if (xt == scsf_pkg::XT_MDMA) begin
                        mdma_mode_o <= xm;
                    end else begin
                        pio_mode_o <= xm;
                    end
                end
                default: ;
            endcase
        end
    end

    // Seek result, flush handshake, width indicator
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seek_o <= 1'b0;
            seek_target_o <= 28'h0000000;
            flush_req_o <= 1'b0;
            wide_io_indicator_n_o <= 1'b1;
            busy_o <= 1'b0;
        end else begin
            seek_o <= seek_ok;
            if (seek_ok) begin
                seek_target_o <= target;
            end
            flush_req_o <= (next_state == scsf_pkg::ST_FLUSH);
            // Low lanes only in 8-bit mode, so no wide access is flagged once 8-bit mode has lasted one cycle
            wide_io_indicator_n_o <= ~(data_acc & ~eight_bit_o);
            busy_o <= next_state != scsf_pkg::ST_IDLE;
        end
    end
endmodule

/* File: tb/scsf_core_props.sv */
`timescale 1ns/1ps
module scsf_core_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus handshake
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    // Modes and status
    input wire logic eight_bit_o,
    input wire logic wide_io_indicator_n_o,
    input wire logic write_cache_o,
    input wire logic read_ahead_o,
    input wire logic pl1_enable_o,
    input wire logic ecc_four_o,
    input wire logic flush_req_o,
    input wire logic busy_o,
    input wire logic seek_o,
    input wire logic [2:0] pio_mode_o,
    input wire logic [2:0] mdma_mode_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_single: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("ack is not a one cycle answer");
    chk_narrow_lanes: assert property (eight_bit_o && $past(eight_bit_o)
        |-> wide_io_indicator_n_o)
        else $error("wide indicator low in 8-bit mode");
    chk_flush_busy: assert property (flush_req_o |-> busy_o)
        else $error("flush running without busy");
    chk_flush_hold: assert property ($rose(flush_req_o) |-> busy_o [*3])
        else $error("completion before flush done");
    chk_pio_range: assert property (pio_mode_o <= scsf_pkg::PIO_MAX)
        else $error("pio mode out of range");
    chk_mdma_range: assert property (mdma_mode_o <= scsf_pkg::MDMA_MAX)
        else $error("mdma mode out of range");
    chk_reset_modes: assert property (disable iff (1'b0) rst_i |=> write_cache_o && read_ahead_o
        && pl1_enable_o && ecc_four_o && !eight_bit_o)
        else $error("mode defaults wrong after reset");
    chk_seek_pulse: assert property (seek_o |=> !seek_o)
        else $error("seek pulse longer than one cycle");
    chk_busy_bound: assert property ($rose(busy_o) |-> ##[1:60] !busy_o)
        else $error("command never completed");
endmodule
bind scsf_core scsf_core_props scsf_core_props_i (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o,
    .eight_bit_o, .wide_io_indicator_n_o, .write_cache_o, .read_ahead_o, .pl1_enable_o,
    .ecc_four_o, .flush_req_o, .busy_o, .seek_o, .pio_mode_o, .mdma_mode_o);

/* File: tb/scsf_host_model.sv */
`timescale 1ns/1ps
module scsf_host_model (
    // Clock
    input wire logic clk_i,
    // Wishbone master
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [5:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o,
    input wire logic [31:0] dat_i,
    input wire logic ack_i
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 6'h3F;
        sel_o = 4'hF;
        dat_o = 32'h0;
    end
    // Task-file access: one bus cycle, given up after 50 clocks without ack
    task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
        output logic [31:0] q, output bit to);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        dat_o <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_i !== 1'b1 && n < 50);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // Released lines flip so stale data never looks valid
        adr_o <= ~a;
        dat_o <= ~{24'h0, d};
        to = (n >= 50);
    endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i, stb_i, we_i, ack_o, eight_bit_o, wide_io_indicator_n_o, write_cache_o;
    logic flush_req_o, read_ahead_o, apm_o, pl1_enable_o, ecc_four_o, seek_o, busy_o;
    logic [5:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, seed = 32'h11, seen = 32'h0;
    logic [5:0] ev = 6'h0;
    logic selftest_fail_i = 1'b0, flush_done_i = 1'b0, data_reg_access_i = 1'b1;
    logic [2:0] selftest_code_i = 3'h2, pio_mode_o, mdma_mode_o, ep = 3'h0, edm = 3'h0;
    logic [27:0] seek_target_o;
    logic [7:0] em = 8'hD8, fl_cnt = 8'h0;
    int error_cnt = 0, checked = 0, sk_n = 0;
    logic [7:0] ft [17] = '{8'h01, 8'h81, 8'h02, 8'h82, 8'h05, 8'h85, 8'h0A, 8'h8A, 8'h44,
        8'hBB, 8'h55, 8'hAA, 8'h66, 8'hCC, 8'h69, 8'h96, 8'h97};
    logic [7:0] eve [6] = '{8'h35, 8'h36, 8'h1F, 8'h22, 8'h32, 8'h01};
    always #5 clk_i = ~clk_i;
    scsf_host_model scsf_host_model_i (.clk_i, .cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i),
        .adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i), .dat_i(dat_o), .ack_i(ack_o));
    scsf_core scsf_core_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
        .ack_o, .soft_reset_i(ev[0]), .selftest_done_i(ev[5]), .selftest_fail_i,
        .selftest_code_i, .volt_supply_bad_i(ev[1]), .volt_gen_bad_i(ev[2]),
        .xfer_error_i(ev[3]), .pl1_cmd_i(ev[4]), .flush_done_i, .data_reg_access_i,
        .eight_bit_o, .wide_io_indicator_n_o, .write_cache_o, .flush_req_o, .read_ahead_o,
        .apm_o, .pl1_enable_o, .ecc_four_o, .pio_mode_o, .mdma_mode_o, .seek_o,
        .seek_target_o, .busy_o);
    // Media answers a flush after a few cycles, long enough to see busy held
    always @(posedge clk_i) begin
        fl_cnt <= flush_req_o ? fl_cnt + 8'h1 : 8'h0;
        flush_done_i <= (fl_cnt >= 8'h6);
        if (seek_o === 1'b1) begin
            seen <= {4'h0, seek_target_o};
            sk_n <= sk_n + 1;
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] upd(input logic [7:0] m, input logic [7:0] f);
        case (f)
            8'h01: m[2] = 1'b1;
            8'h81: m[2] = 1'b0;
            8'h02: m[3] = 1'b1;
            8'h82: m[3] = 1'b0;
            8'h55: m[4] = 1'b0;
            8'hAA: m[4] = 1'b1;
            8'h05: m[5] = 1'b1;
            8'h85: m[5] = 1'b0;
            8'h0A: m[6] = 1'b1;
            8'h8A: m[6] = 1'b0;
            8'hBB: m[7] = 1'b1;
            8'h44: m[7] = 1'b0;
            8'h66: m[1] = 1'b1;
            8'hCC: m[1] = 1'b0;
            default: ;
        endcase
        return m;
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
        output logic [31:0] q);
        bit to;
        scsf_host_model_i.xfer(w, a, d, q, to);
        if (to) error_cnt++;
    endtask
    task automatic cmd(input logic [7:0] op, output logic [7:0] st);
        logic [31:0] q;
        int n;
        bus(1'b1, scsf_pkg::A_CMDSTAT, op, q);
        n = 0;
        do begin
            bus(1'b0, scsf_pkg::A_CMDSTAT, 8'h00, q);
            n++;
        end while (q[7] !== 1'b0 && n < 100);
        st = q[7:0];
    endtask
    task automatic sense(input logic [7:0] exp);
        logic [31:0] q;
        logic [7:0] st;
        cmd(scsf_pkg::CMD_SENSE, st);
        bus(1'b0, scsf_pkg::A_ERROR, 8'h00, q);
        chk("sense", {24'h0, exp}, q);
    endtask
    task automatic setf(input logic [7:0] f, input logic [7:0] sc, output logic [7:0] st);
        logic [31:0] q;
        bus(1'b1, scsf_pkg::A_FEATURE, f, q);
        bus(1'b1, scsf_pkg::A_SECCNT, sc, q);
        cmd(scsf_pkg::CMD_SETF, st);
        em = upd(em, f);
    endtask
    task automatic cmodes(input string nm);
        logic [31:0] q;
        bus(1'b0, scsf_pkg::A_MODES, 8'h00, q);
        chk(nm, 32'({edm, ep, em[7:1]}), 32'(q[13:1]));
        chk("pins", 32'({em[7:2], ep, edm}), 32'({ecc_four_o, pl1_enable_o, apm_o,
            read_ahead_o, write_cache_o, eight_bit_o, pio_mode_o, mdma_mode_o}));
        $display("end of %s", nm);
    endtask
    task automatic pulse(input int k);
        ev[k] <= 1'b1;
        repeat (4) @(posedge clk_i);
        ev[k] <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask
    task automatic seek(input logic [7:0] dh, input logic [7:0] sn, input logic [7:0] ee);
        logic [31:0] q;
        logic [7:0] st;
        bus(1'b1, scsf_pkg::A_SECNUM, sn, q);
        bus(1'b1, scsf_pkg::A_CYLLO, 8'h34, q);
        bus(1'b1, scsf_pkg::A_CYLHI, 8'h12, q);
        bus(1'b1, scsf_pkg::A_DRVHD, dh, q);
        q = rnd();
        cmd({scsf_pkg::CMD_SEEK_HI, q[3:0]}, st);
        chk("seek status", {31'h20, ee != 8'h00}, {24'h0, st});
        sense(ee);
    endtask
    initial begin
        repeat (50000) @(posedge clk_i);
        error_cnt++;
        give_verdict();
    end
    initial begin
        logic [31:0] q;
        logic [7:0] st;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        cmodes("reset");
        bus(1'b0, 6'h3C, 8'h00, q);
        chk("unmapped", 32'h0, q);
        sense(8'h00);
        for (int i = 0; i < 40; i++) begin
            q = rnd();
            setf(ft[q % 17], 8'h00, st);
            chk("feature status", 32'h40, {24'h0, st});
            cmodes("feature");
        end
        setf(8'h01, 8'h00, st);
        chk("wide in 8-bit", 32'h1, 32'(wide_io_indicator_n_o));
        // Back to 16-bit before any DMA mode is chosen
        setf(8'h81, 8'h00, st);
        chk("wide in 16-bit", 32'h0, 32'(wide_io_indicator_n_o));
        data_reg_access_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("wide idle", 32'h1, 32'(wide_io_indicator_n_o));
        for (int i = 0; i < 16; i++) begin
            setf(scsf_pkg::SF_XFER, {i[3] ? scsf_pkg::XT_MDMA : scsf_pkg::XT_PIO, i[2:0]}, st);
            if (i[3] && i[2:0] <= 3'h4) edm = i[2:0];
            if (!i[3] && i[2:0] <= 3'h6) ep = i[2:0];
            chk("xfer status", {31'h20, i[2:0] > (i[3] ? 3'h4 : 3'h6)}, {24'h0, st});
            cmodes("xfer");
        end
        seek(8'hE0, 8'h5A, 8'h00);
        chk("target", 32'h012345A, seen);
        seek(8'hE1, 8'h5A, 8'h2F);
        seek(8'hA0, 8'h00, 8'h21);
        chk("seek pulses", 32'h1, 32'(sk_n));
        seek(8'hA3, 8'h05, 8'h00);
        chk("chs target", (32'h1234 * 16 + 3) * 63 + 4, seen);
        setf(8'h09, 8'h00, st);
        bus(1'b0, scsf_pkg::A_ERROR, 8'h00, q);
        chk("bad sub", 32'h4104, 32'({st, q[7:0]}));
        sense(8'h20);
        sense(8'h00);
        cmd(scsf_pkg::CMD_NOP, st);
        chk("nop status", 32'h41, {24'h0, st});
        sense(8'h1F);
        cmd(8'hC0, st);
        sense(8'h20);
        setf(8'h8A, 8'h00, st);
        for (int i = 0; i < 6; i++) begin
            selftest_fail_i <= (i == 4);
            pulse(i < 4 ? i + 1 : 5);
            sense(eve[i]);
        end
        setf(8'h55, 8'h00, st);
        setf(8'h66, 8'h00, st);
        pulse(0);
        cmodes("soft reset kept");
        setf(8'hCC, 8'h00, st);
        pulse(0);
        em = 8'hD8;
        ep = 3'h0;
        edm = 3'h0;
        cmodes("soft reset defaults");
        give_verdict();
    end
endmodule
